// [hw/ulms_regs.sv]
// Purpose: Line status, modem status, scratch and level registers over APB
// Assumes: Receiver and transmitter cores sit outside and report events
// Notes: Every APB transfer takes one wait state so read data is registered
`include "ulms_defines.svh"
`default_nettype none
module ulms_regs
  import ulms_pkg::*;
(
  // Clock and reset
  input  wire logic          sys_clk_in,
  input  wire logic          rst_n_in,
  // APB slave
  input  wire logic          psel_in,
  input  wire logic          penable_in,
  input  wire logic          pwrite_in,
  input  wire logic [11:0]   paddr_in,
  input  wire logic [31:0]   pwdata_in,
  output logic [31:0]        prdata_out,
  output logic               pready_out,
  output logic               pslverr_out,
  // Receiver side
  input  wire ulms_rx_char_s rx_char_in,
  input  wire logic          rx_char_valid_in,
  input  wire logic          rx_break_in,
  input  wire logic          rx_pop_in,
  input  wire logic          fifo_mode_in,
  output ulms_rx_char_s      rx_head_out,
  // Transmitter side
  input  wire logic          tx_write_in,
  input  wire logic          tx_load_shift_in,
  input  wire logic          tx_shift_busy_in,
  // Modem status interrupt
  input  wire logic          irq_enable_msr_in,
  output logic               modem_irq_out,
  // Baud and flow control
  output logic               baud_tick_out,
  output logic [5:0]         hyst_chars_out
);

  ////////////////////////////////////////////////////////////////////////
  // Lookup for flow control hysteresis
  function automatic logic [5:0] hyst_lookup(input logic [3:0] code);
    logic [5:0] v;
    v = 6'h00;
    unique case (code)
      4'h0: v = 6'h00;
      4'h1: v = 6'h04;
      4'h2: v = 6'h06;
      4'h3: v = 6'h08;
      4'h4: v = 6'h08;
      4'h5: v = 6'h10;
      4'h6: v = 6'h18;
      4'h7: v = 6'h20;
      4'h8: v = 6'h28;
      4'h9: v = 6'h2c;
      4'ha: v = 6'h30;
      4'hb: v = 6'h34;
      4'hc: v = 6'h0c;
      4'hd: v = 6'h14;
      4'he: v = 6'h1c;
      4'hf: v = 6'h24;
    endcase
    return v;
  endfunction

  // Shared occupancy arithmetic for the store counters
  function automatic logic [6:0] count_step(input logic [6:0] cnt,
                                            input logic [6:0] up,
                                            input logic [6:0] dn);
    return cnt + up - dn;
  endfunction

  function automatic logic is_empty(input logic [6:0] cnt);
    return cnt == 7'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]     modem_ctrl_reg;
  logic           enh_enable_reg;
  logic [7:0]     feature_ctrl_reg;
  logic [7:0]     scratch_byte_reg;
  logic [7:0]     enh_select_reg;
  logic           alt_tx_reg;
  logic           overrun_reg;
  logic [3:0]     delta_reg;
  logic [3:0]     loop_prev_reg;
  logic [1:0]     prescale_reg;
  logic           brk_prev_reg;
  logic           ack_reg;
  logic [31:0]    prdata_reg;
  ulms_rx_char_s  rx_mem [0:63];
  logic [5:0]     rx_rd_ptr_reg;
  logic [5:0]     rx_wr_ptr_reg;
  logic [6:0]     rx_count_reg;
  logic [6:0]     rx_err_count_reg;
  logic [6:0]     tx_count_reg;

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  wire logic acc_phase  = psel_in & penable_in;
  wire logic done       = acc_phase & ack_reg;
  wire logic hit_mcr    = (paddr_in == `ULMS_OFF_MODEM_CTRL);
  wire logic hit_lsr    = (paddr_in == `ULMS_OFF_LINE_STATE);
  wire logic hit_msr    = (paddr_in == `ULMS_OFF_MODEM_STATE);
  wire logic hit_spr    = (paddr_in == `ULMS_OFF_SCRATCH);
  wire logic hit_feature_ctrl_reg   = (paddr_in == `ULMS_OFF_FEATURE_CTRL);
  wire logic hit_efr    = (paddr_in == `ULMS_OFF_ENH_FEATURE);
  wire logic hit_any    = hit_mcr | hit_lsr | hit_msr | hit_spr | hit_feature_ctrl_reg | hit_efr;
  wire logic wr_done    = done & pwrite_in & hit_any;
  wire logic rd_done    = done & ~pwrite_in & hit_any;
  wire logic swap_on    = feature_ctrl_reg[`ULMS_FEATURE_CTRL_REG_SWAP];
  wire logic wr_mcr     = wr_done & hit_mcr;
  wire logic wr_feature_ctrl_reg    = wr_done & hit_feature_ctrl_reg;
  wire logic wr_efr     = wr_done & hit_efr;
  wire logic wr_spr     = wr_done & hit_spr & ~swap_on;
  wire logic wr_enhanced_select_write    = wr_done & hit_spr & swap_on;
  wire logic rd_lsr     = rd_done & hit_lsr;
  wire logic rd_msr     = rd_done & hit_msr;
  wire logic rd_flvl    = rd_done & hit_spr & swap_on;

  assign pready_out  = done;
  assign pslverr_out = done & ~hit_any;
  assign prdata_out  = prdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // Prescaler: tick every cycle or every fourth
  wire logic prescale_div4 = modem_ctrl_reg[`ULMS_MCR_PRESCALE];
  assign baud_tick_out = ~prescale_div4 | (prescale_reg == `ULMS_PRESCALE_DIV);

  // Prescale bit only moves with enhanced functions on
  wire logic [7:0] mcr_next = {enh_enable_reg ? pwdata_in[7] : modem_ctrl_reg[7],
                               pwdata_in[6:0]};

  ////////////////////////////////////////////////////////////////////////
  // Receive store with per-character error tags
  wire logic rx_any   = ~is_empty(rx_count_reg);
  wire logic rx_full  = fifo_mode_in ? (rx_count_reg == `ULMS_FIFO_DEPTH)
                                     : rx_any;
  wire logic brk_edge = rx_break_in & ~brk_prev_reg;
  // Break wins over a character in the same cycle; only one break entry per break
  wire ulms_rx_char_s brk_char   = '{brk: 1'b1, frm: 1'b0, par: 1'b0, data: 8'h00};
  wire ulms_rx_char_s rx_in_char = brk_edge ? brk_char : rx_char_in;
  wire logic rx_arrive = brk_edge | rx_char_valid_in;
  wire logic rx_pop    = rx_pop_in & rx_any;
  wire logic rx_push   = rx_arrive & (~rx_full | rx_pop) & ~(rx_full & ~rx_pop);
  wire logic rx_drop   = rx_arrive & rx_full & ~rx_pop;
  wire ulms_rx_char_s head = rx_mem[rx_rd_ptr_reg];
  wire logic in_err    = rx_in_char.brk | rx_in_char.frm | rx_in_char.par;
  wire logic head_err  = head.brk | head.frm | head.par;
  wire logic [6:0] err_up = (rx_push & in_err) ? 7'h01 : 7'h00;
  wire logic [6:0] err_dn = (rx_pop & head_err) ? 7'h01 : 7'h00;
  wire logic [6:0] rx_up  = rx_push ? 7'h01 : 7'h00;
  wire logic [6:0] rx_dn  = rx_pop ? 7'h01 : 7'h00;

  assign rx_head_out = head;

  ////////////////////////////////////////////////////////////////////////
  // Transmit occupancy, held here from host writes and shifter loads
  wire logic tx_dec      = tx_load_shift_in & ~is_empty(tx_count_reg);
  wire logic tx_inc      = tx_write_in & (tx_count_reg != `ULMS_FIFO_DEPTH);
  wire logic [6:0] tx_up = tx_inc ? 7'h01 : 7'h00;
  wire logic [6:0] tx_dn = tx_dec ? 7'h01 : 7'h00;
  wire logic thr_empty   = is_empty(tx_count_reg);
  wire logic tx_idle     = thr_empty & ~tx_shift_busy_in;

  ////////////////////////////////////////////////////////////////////////
  // Line status assembly
  wire logic [7:0] lsr_val = {
    fifo_mode_in & ~is_empty(rx_err_count_reg),
    tx_idle,
    thr_empty,
    rx_any & head.brk,
    rx_any & head.frm,
    rx_any & head.par,
    overrun_reg,
    rx_any
  };

  ////////////////////////////////////////////////////////////////////////
  // Modem status, live only in loopback
  wire logic loop_on = modem_ctrl_reg[`ULMS_MCR_LOOP];
  // Order: cd, ri, dsr, cts
  wire logic [3:0] loop_lvl = loop_on ? {modem_ctrl_reg[`ULMS_MCR_OP2],
                                         modem_ctrl_reg[`ULMS_MCR_OP1],
                                         modem_ctrl_reg[`ULMS_MCR_DTR],
                                         modem_ctrl_reg[`ULMS_MCR_RTS]}
                                      : 4'h0;
  wire logic [3:0] lvl_chg  = loop_lvl ^ loop_prev_reg;
  // Ring end: ring pin low to high is the status bit falling
  wire logic [3:0] delta_set = loop_on ? {lvl_chg[3],
                                          loop_prev_reg[2] & ~loop_lvl[2],
                                          lvl_chg[1],
                                          lvl_chg[0]}
                                       : 4'h0;
  // A change landing in the clearing read is kept
  wire logic [3:0] delta_next = (rd_msr ? 4'h0 : delta_reg) | delta_set;
  wire logic [7:0] msr_val    = {loop_lvl, delta_reg};

  assign modem_irq_out = irq_enable_msr_in & (delta_reg != 4'h0);

  ////////////////////////////////////////////////////////////////////////
  // Level report and hysteresis
  wire ulms_lvl_mode_e lvl_mode = ~enh_select_reg[0] ? ULMS_LVL_RX :
                                  (enh_select_reg[1] ? ULMS_LVL_ALT : ULMS_LVL_TX);
  logic [7:0] flvl_val;
  always_comb
  begin
    flvl_val = 8'h00;
    unique case (lvl_mode)
      ULMS_LVL_RX:  flvl_val = {1'b0, rx_count_reg};
      ULMS_LVL_TX:  flvl_val = {1'b0, tx_count_reg};
      ULMS_LVL_ALT: flvl_val = {1'b0, alt_tx_reg ? tx_count_reg : rx_count_reg};
    endcase
  end

  assign hyst_chars_out = hyst_lookup({enh_select_reg[5:4], feature_ctrl_reg[1:0]});

  wire logic [7:0] spr_rd = swap_on ? flvl_val : scratch_byte_reg;

  wire logic [7:0] rd_mux = hit_mcr  ? modem_ctrl_reg :
                            hit_lsr  ? lsr_val :
                            hit_msr  ? msr_val :
                            hit_spr  ? spr_rd :
                            hit_feature_ctrl_reg ? feature_ctrl_reg :
                            hit_efr  ? {3'h0, enh_enable_reg, 4'h0} : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake and read data
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      ack_reg    <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg    <= acc_phase & ~ack_reg;
      prdata_reg <= (acc_phase & ~ack_reg & ~pwrite_in) ? {24'h00_0000, rd_mux} : prdata_reg;
    end
  end

  // Software-written registers
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      modem_ctrl_reg   <= `ULMS_RST_ZERO8;
      enh_enable_reg   <= 1'b0;
      feature_ctrl_reg <= `ULMS_RST_ZERO8;
      scratch_byte_reg <= `ULMS_RST_SCRATCH;
      enh_select_reg   <= `ULMS_RST_ZERO8;
    end
    else
    begin
      if (wr_mcr)
        modem_ctrl_reg <= mcr_next;
      if (wr_efr)
        enh_enable_reg <= pwdata_in[`ULMS_EFR_ENH];
      if (wr_feature_ctrl_reg)
        feature_ctrl_reg <= pwdata_in[7:0];
      if (wr_spr)
        scratch_byte_reg <= pwdata_in[7:0];
      if (wr_enhanced_select_write)
        enh_select_reg <= pwdata_in[7:0];
    end
  end

  // Alternate level pointer: restarts on receive at each select write
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      alt_tx_reg <= 1'b0;
    else if (wr_enhanced_select_write)
      alt_tx_reg <= 1'b0;
    else if (rd_flvl & (lvl_mode == ULMS_LVL_ALT))
      alt_tx_reg <= ~alt_tx_reg;
  end

  // Status flags; a new event beats the clearing read
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      overrun_reg   <= 1'b0;
      delta_reg     <= 4'h0;
      loop_prev_reg <= 4'h0;
      brk_prev_reg  <= 1'b0;
    end
    else
    begin
      overrun_reg   <= rx_drop | (overrun_reg & ~rd_lsr);
      delta_reg     <= delta_next;
      loop_prev_reg <= loop_lvl;
      brk_prev_reg  <= rx_break_in;
    end
  end

  // Prescale counter runs only while dividing, so it restarts at zero
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      prescale_reg <= 2'h0;
    else
      prescale_reg <= prescale_div4 ? prescale_reg + 2'h1 : 2'h0;
  end

  // Receive store pointers and counts
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      rx_rd_ptr_reg    <= 6'h00;
      rx_wr_ptr_reg    <= 6'h00;
      rx_count_reg     <= 7'h00;
      rx_err_count_reg <= 7'h00;
    end
    else
    begin
      if (rx_push)
        rx_wr_ptr_reg <= rx_wr_ptr_reg + 6'h01;
      if (rx_pop)
        rx_rd_ptr_reg <= rx_rd_ptr_reg + 6'h01;
      rx_count_reg     <= count_step(rx_count_reg, rx_up, rx_dn);
      rx_err_count_reg <= count_step(rx_err_count_reg, err_up, err_dn);
    end
  end

  // Transmit occupancy; saturates rather than wraps on a runaway host
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      tx_count_reg <= 7'h00;
    else
      tx_count_reg <= count_step(tx_count_reg, tx_up, tx_dn);
  end

  // Store contents; no reset so the array maps to plain storage
  always_ff @(posedge sys_clk_in)
  begin
    if (rx_push)
      rx_mem[rx_wr_ptr_reg] <= rx_in_char;
  end

endmodule
`default_nettype wire

// [hw/ulms_defines.svh]
// Purpose: Constants for the UART line, modem status and scratch block
// Assumes: APB word addresses, 100 MHz system clock
// Notes:
// How it works
// - Prescaler bit picks divide by one or four
// - Data ready while receive store holds characters
// - Full store: flag overrun, drop new character
// - Parity tag follows head character
// - Framing tag follows head character
// - Long low line: break flag, one character
// - Holding empty tracks transmit store emptiness
// - Idle only when store and shifter empty
// - Error summary while any stored character errs, in FIFO mode only
// - Loopback input changes set delta bits, interrupt
// - Ring delta only at ringing end
// - Loopback status bits mirror modem control bits
// - Scratch byte resets to all ones
// - Swap bit steers scratch writes to select
// - Select bits pick reported level
// - Alternate mode starts receive, then alternates
// - Hysteresis from four-bit code lookup
// - Loopback bit enables modem status inputs
`ifndef ULMS_DEFINES_SVH
`define ULMS_DEFINES_SVH

`define ULMS_OFF_MODEM_CTRL   12'h000
`define ULMS_OFF_LINE_STATE   12'h004
`define ULMS_OFF_MODEM_STATE  12'h008
`define ULMS_OFF_SCRATCH      12'h00c
`define ULMS_OFF_FEATURE_CTRL 12'h010
`define ULMS_OFF_ENH_FEATURE  12'h014

`define ULMS_MCR_DTR      0
`define ULMS_MCR_RTS      1
`define ULMS_MCR_OP1      2
`define ULMS_MCR_OP2      3
`define ULMS_MCR_LOOP     4
`define ULMS_MCR_PRESCALE 7
`define ULMS_EFR_ENH      4
`define ULMS_FEATURE_CTRL_REG_SWAP    6

`define ULMS_RST_SCRATCH  8'hff
`define ULMS_RST_ZERO8    8'h00
`define ULMS_PRESCALE_DIV 2'h3
`define ULMS_FIFO_DEPTH   7'h40

`endif

// [hw/ulms_pkg.sv]
// Purpose: Types shared by the UART status block
// Assumes: Constants live in ulms_defines.svh
// Notes: Receive characters carry their error tags
`default_nettype none
package ulms_pkg;
  typedef struct packed {
    logic       brk;
    logic       frm;
    logic       par;
    logic [7:0] data;
  } ulms_rx_char_s;

  typedef enum logic [1:0] {
    ULMS_LVL_RX,
    ULMS_LVL_TX,
    ULMS_LVL_ALT
  } ulms_lvl_mode_e;
endpackage
`default_nettype wire

// [verification/ulms_regs_assertions.sv]
// Purpose: Port checks for ulms_regs
// Assumes: Sync active-low reset, one clock
// Notes: Stores and deltas are internal; only port effects checked
`default_nettype none
module ulms_regs_assertions
(
  // Clock and reset
  input wire logic        sys_clk_in,
  input wire logic        rst_n_in,
  // APB
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // Interrupt enable and status outputs
  input wire logic        irq_enable_msr_in,
  input wire logic        modem_irq_out,
  input wire logic        baud_tick_out,
  input wire logic [5:0]  hyst_chars_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_wait;
    !pready_out ##1 pready_out;
  endsequence
  a_apb_wait: assert property (s_setup |=> s_wait)
    else $error("pready not two cycles after setup");
  a_ready_cause: assert property (pready_out |-> psel_in && penable_in && $past(penable_in))
    else $error("pready outside an access phase");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  a_err_data: assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
    else $error("unmapped read data not zero");
  a_rd_upper: assert property (prdata_out[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_tick_div: assert property (!baud_tick_out |-> ##[1:3] baud_tick_out)
    else $error("baud tick gap above four");
  a_irq_mask: assert property (modem_irq_out |-> irq_enable_msr_in)
    else $error("modem irq while disabled");
  // Only a completed read may clear deltas
  a_irq_hold: assert property (modem_irq_out && !(psel_in && penable_in && pready_out)
    |=> modem_irq_out || !irq_enable_msr_in)
    else $error("modem irq dropped without read");
  a_hyst_code: assert property (hyst_chars_out inside {6'h00, 6'h04, 6'h06, 6'h08, 6'h10,
    6'h18, 6'h20, 6'h28, 6'h2c, 6'h30, 6'h34, 6'h0c, 6'h14, 6'h1c, 6'h24})
    else $error("hysteresis value off table");
  a_reset_out: assert property (!$past(rst_n_in) |-> !pready_out && !modem_irq_out
    && hyst_chars_out == 6'h00 && baud_tick_out)
    else $error("outputs wrong after reset");
endmodule

bind ulms_regs ulms_regs_assertions i_ulms_regs_assertions (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .irq_enable_msr_in(irq_enable_msr_in), .modem_irq_out(modem_irq_out),
  .baud_tick_out(baud_tick_out), .hyst_chars_out(hyst_chars_out)
);
`default_nettype wire

// [verification/ulms_line_node.sv]
// Purpose: Remote serial node feeding received characters
// Assumes: Receiver core reports one pulse per character
// Notes: Char lines show garbage outside a pulse
`default_nettype none
module ulms_line_node
  import ulms_pkg::*;
(
  // Clock
  input  wire logic          sys_clk_in,
  // Bench requests
  input  wire logic          send_in,
  input  wire ulms_rx_char_s char_in,
  input  wire logic          brk_in,
  // Receiver events
  output ulms_rx_char_s      rx_char_out,
  output logic               rx_valid_out,
  output logic               rx_break_out
);
  // Inverted value between pulses, so a stale char never looks valid
  always_ff @(posedge sys_clk_in)
  begin
    rx_valid_out <= send_in;
    rx_char_out  <= send_in ? char_in : ~char_in;
    rx_break_out <= brk_in;
  end
endmodule
`default_nettype wire

// [verification/uart_line_modem_status_regs_bench.sv]
// Purpose: Self-checking bench for ulms_regs
// Assumes: One wait state per APB transfer
// Notes: Table rows first, then hand cases
`include "ulms_defines.svh"
`default_nettype none
module uart_line_modem_status_regs_bench
  import ulms_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [11:0] a; logic [1:0] k; logic [7:0] v;} ulms_row_s;
  localparam logic [11:0] A_MC = `ULMS_OFF_MODEM_CTRL;
  localparam logic [11:0] A_LS = `ULMS_OFF_LINE_STATE;
  localparam logic [11:0] A_MS = `ULMS_OFF_MODEM_STATE;
  localparam logic [11:0] A_SC = `ULMS_OFF_SCRATCH;
  localparam logic [11:0] A_FC = `ULMS_OFF_FEATURE_CTRL;
  localparam logic [11:0] A_EF = `ULMS_OFF_ENH_FEATURE;
  logic          clk, rst_n, psel, pen, pwr, pop, fifo, txw, txl, busy, irq_en;
  logic          snd, brk, rv, rb, pready, perr, err, irq, tick;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rd, cnt;
  logic [5:0]    hyst;
  ulms_rx_char_s chr, rc, head;
  int            miscompares, n_tests;
  logic [5:0]    hyst_tab [16] = '{6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10, 6'h18, 6'h20,
                                   6'h28, 6'h2c, 6'h30, 6'h34, 6'h0c, 6'h14, 6'h1c, 6'h24};
  // Kind 0 read and compare, 1 write, 2 read and ignore
  ulms_row_s     rows [20] = '{
    '{A_LS, 2'h0, 8'h60}, '{A_MC, 2'h1, 8'h10}, '{A_MS, 2'h2, 8'h00}, '{A_MC, 2'h1, 8'h1b},
    '{A_MS, 2'h0, 8'hbb}, '{A_MS, 2'h0, 8'hb0}, '{A_MC, 2'h1, 8'h1f}, '{A_MS, 2'h0, 8'hf0},
    '{A_MC, 2'h1, 8'h1b}, '{A_MS, 2'h0, 8'hb4}, '{A_MC, 2'h1, 8'h00}, '{A_MS, 2'h2, 8'h00},
    '{A_MS, 2'h0, 8'h00}, '{A_MC, 2'h1, 8'h80}, '{A_MC, 2'h0, 8'h00}, '{A_EF, 2'h1, 8'h10},
    '{A_MC, 2'h1, 8'h80}, '{A_MC, 2'h0, 8'h80}, '{A_SC, 2'h1, 8'h5a}, '{A_SC, 2'h0, 8'h5a}};
  ////////////////////////////////////////////////////////////////////////////////
  ulms_regs i_ulms_regs (.sys_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr), .rx_char_in(rc),
    .rx_char_valid_in(rv), .rx_break_in(rb), .rx_pop_in(pop), .fifo_mode_in(fifo),
    .rx_head_out(head), .tx_write_in(txw), .tx_load_shift_in(txl),
    .tx_shift_busy_in(busy), .irq_enable_msr_in(irq_en), .modem_irq_out(irq),
    .baud_tick_out(tick), .hyst_chars_out(hyst));
  ulms_line_node i_ulms_line_node (.sys_clk_in(clk), .send_in(snd), .char_in(chr),
    .brk_in(brk), .rx_char_out(rc), .rx_valid_out(rv), .rx_break_out(rb));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("Compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask
  // Request held until pready is sampled high
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
    if (pready !== 1'b1)
    begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    apb(a, 1'b0, 8'h00);
    chk("read", rd, {24'h0, e});
  endtask
  task automatic send(input ulms_rx_char_s c);
    @(posedge clk);
    snd <= 1'b1;
    chr <= c;
    @(posedge clk);
    snd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic popc();
    @(posedge clk);
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    {rst_n, psel, pen, pwr, pop, txw, txl, busy, snd, brk} = '0;
    {fifo, irq_en, paddr, pwdata, chr} = {2'h3, 55'h0};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].a, rows[i].k == 2'h1, rows[i].v);
      if (rows[i].k == 2'h0)
        chk("row", rd, {24'h0, rows[i].v});
    end
    cnt = 32'h0;
    repeat (8) @(posedge clk) cnt = cnt + {31'h0, tick};
    chk("tick", cnt, 32'h2);
    apb(A_MC, 1'b1, 8'h99);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h1);
    irq_en <= 1'b0;
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    irq_en <= 1'b1;
    rdc(A_MS, 8'haa);
    @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    apb(A_MC, 1'b1, 8'h00);
    cnt = 32'h0;
    repeat (8) @(posedge clk) cnt = cnt + {31'h0, tick};
    chk("tick", cnt, 32'h8);
    // Tagged chars through the store
    send(11'h141);
    send(11'h042);
    rdc(A_LS, 8'he5);
    chk("head", {21'h0, head}, 32'h141);
    popc();
    rdc(A_LS, 8'h61);
    send(11'h243);
    rdc(A_LS, 8'he1);
    popc();
    rdc(A_LS, 8'he9);
    popc();
    rdc(A_LS, 8'h60);
    brk <= 1'b1;
    repeat (6) @(posedge clk);
    brk <= 1'b0;
    rdc(A_LS, 8'hf1);
    apb(A_FC, 1'b1, 8'h40);
    rdc(A_SC, 8'h01);
    popc();
    send(11'h055);
    send(11'h056);
    repeat (5) @(posedge clk) txw <= ~txw;
    @(posedge clk) txw <= 1'b0;
    rdc(A_SC, 8'h02);
    apb(A_SC, 1'b1, 8'h01);
    rdc(A_SC, 8'h03);
    apb(A_SC, 1'b1, 8'h03);
    for (int k = 0; k < 3; k++)
      rdc(A_SC, k[0] ? 8'h03 : 8'h02);
    rdc(A_LS, 8'h01);
    busy <= 1'b1;
    repeat (6) @(posedge clk) txl <= ~txl;
    rdc(A_LS, 8'h21);
    busy <= 1'b0;
    rdc(A_LS, 8'h61);
    apb(A_FC, 1'b1, 8'h00);
    rdc(A_SC, 8'h5a);
    // Single slot: second char is dropped
    popc();
    popc();
    fifo <= 1'b0;
    send(11'h044);
    send(11'h045);
    rdc(A_LS, 8'h63);
    chk("head", {21'h0, head}, 32'h044);
    rdc(A_LS, 8'h61);
    popc();
    fifo <= 1'b1;
    for (int k = 0; k < 16; k++)
    begin
      apb(A_FC, 1'b1, {6'h10, k[1:0]});
      apb(A_SC, 1'b1, {2'h0, k[3:2], 4'h0});
      @(posedge clk);
      chk("hyst", {26'h0, hyst}, {26'h0, hyst_tab[k]});
    end
    apb(12'h0f0, 1'b0, 8'h00);
    chk("slverr", {31'h0, err}, 32'h1);
    chk("rdata", rd, 32'h0);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rdc(A_SC, 8'hff);
    rdc(A_MC, 8'h00);
    rdc(A_LS, 8'h60);
    test_done();
  end
endmodule
`default_nettype wire
